//--- common/tap_pkg.sv
// package: constants, types and decoding for the memory's test access port
// assumes one core clock domain that samples the test pins through synchronisers
// How it works
// - capture-ir loads 01 into low instruction bits
// - shift-ir places instruction shifter between tdi, tdo
// - new instruction acts only at update-ir
// - bypass selects one-bit bypass cell in shift-dr
// - sample/preload captures input pins in capture-dr
// - pinless scan cells capture their fixed defaults
// - sample/preload shifts boundary register in shift-dr
// - all-zero instruction decodes as extest
// - extest never blocks the memory's input pins
// - extest at update-ir drives scan cells out
// - extest captures pins, output pins follow cells
// - idcode captures rom word, shifts it out
// - idcode loaded at reset and test-logic-reset
// - sample_highz floats outputs, selects boundary register
// - reserved_instruction codes behave like bypass
// - codes 000 extest, 001 idcode, 010 sample_highz
// - instruction register is three bits wide
// - device_identification bit 0 leaves tdo first
// - five tms-high rising edges reach test-logic-reset
`default_nettype none
package tap_pkg;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE_HIGHZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] TLR_TMS_EDGES = 3'h5;
  localparam int ID_MAKER_MSB = 11;
  localparam int ID_MAKER_LSB = 1;
  localparam logic ID_PRESENCE = 1'h1;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR,
    EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_pins_s;

  typedef struct packed {
    logic bsr;
    logic idr;
    logic byp;
    logic highz;
    logic extest;
  } ins_sel_s;

  function automatic ins_sel_s decode_ins(input logic [IR_W-1:0] ir);
    ins_sel_s s;
    s = '0;
    unique case (ir)
      INS_EXTEST: begin
        s.bsr = 1'b1;
        s.extest = 1'b1;
      end
      INS_IDCODE: s.idr = 1'b1;
      INS_SAMPLE_HIGHZ: begin
        s.bsr = 1'b1;
        s.highz = 1'b1;
      end
      INS_SAMPLE_PRELOAD: s.bsr = 1'b1;
      default: s.byp = 1'b1;
    endcase
    return s;
  endfunction
endpackage
`default_nettype wire

//--- hw/tap_id_rom.sv
// identification rom with registered read word
// assumes a static word; maker code value is arbitrary
`default_nettype none
module tap_id_rom
  import tap_pkg::*;
#(
  parameter logic [10:0] MAKER_CODE = 11'h2a5, // arbitrary value
  parameter logic [19:0] UPPER_BITS = 20'h0_0000
) (
  input wire logic core_clk,
  output logic [ID_W-1:0] id_word
);
  logic [ID_W-1:0] word_reg;

  always_ff @(posedge core_clk) begin
    word_reg <= {UPPER_BITS, MAKER_CODE, ID_PRESENCE};
  end

  assign id_word = word_reg;
endmodule
`default_nettype wire

//--- hw/tap_instruction_logic.sv
// instruction handling, data register selection and pin effects of the test port
// assumes tck, tms, tdi and memory pins are asynchronous and sampled by core_clk
`default_nettype none
module tap_instruction_logic
  import tap_pkg::*;
#(
  parameter int BSR_LEN = 16,
  parameter logic [BSR_LEN-1:0] PINLESS_MASK = 16'h8001,
  parameter logic [BSR_LEN-1:0] PINLESS_VALUE = 16'hffff,
  parameter logic [10:0] MAKER_CODE = 11'h2a5 // arbitrary value
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire jtag_pins_s jtag_in,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_LEN-1:0] pin_in,
  output logic [BSR_LEN-1:0] drive_data,
  output logic drive_en,
  output logic outputs_highz
);
  generate
    if (BSR_LEN < 2) begin : g_chk
      $error("BSR_LEN must be at least 2");
    end
  endgenerate

  jtag_pins_s jtag_s;
  logic [BSR_LEN-1:0] pin_s;
  logic [ID_W-1:0] rom_word;
  logic tck_d_reg;
  tap_state_e state_reg, state_next;
  logic [IR_W-1:0] ir_reg;
  logic [IR_W-1:0] ir_shift_reg;
  logic bypass_reg;
  logic [ID_W-1:0] id_shift_reg;
  logic [BSR_LEN-1:0] bsr_reg;
  logic [BSR_LEN-1:0] upd_reg;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic [2:0] ones_cnt_reg;

  tap_sync #(.W(3)) u_jtag_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(jtag_in),
    .sync_out(jtag_s)
  );

  tap_sync #(.W(BSR_LEN)) u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  tap_id_rom #(.MAKER_CODE(MAKER_CODE)) u_rom (
    .core_clk(core_clk),
    .id_word(rom_word)
  );

  // tck edges seen by the core clock
  wire tck_rise = jtag_s.tck & ~tck_d_reg;
  wire tck_fall = ~jtag_s.tck & tck_d_reg;
  wire ins_sel_s sel = decode_ins(ir_reg);
  wire ins_sel_s sel_new = decode_ins(ir_shift_reg);
  wire in_tlr = (state_reg == TEST_LOGIC_RESET);
  wire cap_dr = tck_rise && (state_reg == CAPTURE_DR);
  wire sh_dr = tck_rise && (state_reg == SHIFT_DR);
  // pins only observed; pinless cells take defaults
  wire [BSR_LEN-1:0] cap_vec = (pin_s & ~PINLESS_MASK) | (PINLESS_VALUE & PINLESS_MASK);
  wire dr_lsb = sel.bsr ? bsr_reg[0] : (sel.idr ? id_shift_reg[0] : bypass_reg);
  wire upd_ir_extest = (state_reg == UPDATE_IR) && sel_new.extest;
  wire upd_dr_extest = (state_reg == UPDATE_DR) && sel.extest;
  wire shifting = (state_reg == SHIFT_DR) || (state_reg == SHIFT_IR);

  // controller state walk on tms
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TEST_LOGIC_RESET: state_next = jtag_s.tms ? TEST_LOGIC_RESET : RUN_IDLE;
      RUN_IDLE: state_next = jtag_s.tms ? SELECT_DR : RUN_IDLE;
      SELECT_DR: state_next = jtag_s.tms ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: state_next = jtag_s.tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: state_next = jtag_s.tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: state_next = jtag_s.tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: state_next = jtag_s.tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: state_next = jtag_s.tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: state_next = jtag_s.tms ? SELECT_DR : RUN_IDLE;
      SELECT_IR: state_next = jtag_s.tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: state_next = jtag_s.tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: state_next = jtag_s.tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: state_next = jtag_s.tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: state_next = jtag_s.tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: state_next = jtag_s.tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: state_next = jtag_s.tms ? SELECT_DR : RUN_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tck_d_reg <= 1'b0;
      state_reg <= TEST_LOGIC_RESET;
    end else begin
      tck_d_reg <= jtag_s.tck;
      if (tck_rise) begin
        state_reg <= state_next;
      end
    end
  end

  // instruction shifter and active instruction
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ir_shift_reg <= INS_IDCODE;
      ir_reg <= INS_IDCODE;
    end else begin
      if (tck_rise && state_reg == CAPTURE_IR) begin
        ir_shift_reg <= IR_CAPTURE;
      end else if (tck_rise && state_reg == SHIFT_IR) begin
        ir_shift_reg <= {jtag_s.tdi, ir_shift_reg[IR_W-1:1]};
      end
      if (in_tlr) begin
        ir_reg <= INS_IDCODE;
      end else if (tck_fall && state_reg == UPDATE_IR) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // data registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bypass_reg <= 1'b0;
      id_shift_reg <= '0;
    end else begin
      if (cap_dr && sel.byp) begin
        bypass_reg <= 1'b0;
      end else if (sh_dr && sel.byp) begin
        bypass_reg <= jtag_s.tdi;
      end
      if (cap_dr && sel.idr) begin
        id_shift_reg <= rom_word;
      end else if (sh_dr && sel.idr) begin
        id_shift_reg <= {jtag_s.tdi, id_shift_reg[ID_W-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bsr_reg <= '0;
      upd_reg <= '0;
    end else begin
      if (cap_dr && sel.bsr) begin
        bsr_reg <= cap_vec;
      end else if (sh_dr && sel.bsr) begin
        bsr_reg <= {jtag_s.tdi, bsr_reg[BSR_LEN-1:1]};
      end
      if (tck_fall && (upd_ir_extest || upd_dr_extest)) begin
        upd_reg <= bsr_reg;
      end
    end
  end

  // tdo changes on the falling tck edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_reg <= shifting;
      if (state_reg == SHIFT_IR) begin
        tdo_reg <= ir_shift_reg[0];
      end else if (state_reg == SHIFT_DR) begin
        tdo_reg <= dr_lsb;
      end
    end
  end

  // consecutive tms-high edges, for checking only
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ones_cnt_reg <= 3'h0;
    end else if (tck_rise) begin
      if (!jtag_s.tms) begin
        ones_cnt_reg <= 3'h0;
      end else if (ones_cnt_reg != TLR_TMS_EDGES) begin
        ones_cnt_reg <= ones_cnt_reg + 3'h1;
      end
    end
  end

  assign tdo = tdo_reg;
  assign tdo_oe = tdo_oe_reg;
  assign drive_data = upd_reg;
  assign drive_en = sel.extest;
  assign outputs_highz = sel.highz;

  property p_capture_ir;
    @(posedge core_clk) disable iff (!nrst)
    tck_rise && state_reg == CAPTURE_IR |=> ir_shift_reg[1:0] == 2'h1;
  endproperty
  a_capture_ir: assert property (p_capture_ir) else $error("capture-ir pattern wrong");

  property p_shift_ir_tdo;
    @(posedge core_clk) disable iff (!nrst)
    tck_fall && state_reg == SHIFT_IR |=> tdo_reg == $past(ir_shift_reg[0]) && tdo_oe_reg;
  endproperty
  a_shift_ir_tdo: assert property (p_shift_ir_tdo) else $error("shift-ir tdo wrong");

  property p_ir_update_only;
    @(posedge core_clk) disable iff (!nrst)
    ir_reg != $past(ir_reg) |-> $past(tck_fall && state_reg == UPDATE_IR) || $past(in_tlr);
  endproperty
  a_ir_update_only: assert property (p_ir_update_only) else $error("instruction changed early");

  property p_bypass_tdo;
    @(posedge core_clk) disable iff (!nrst)
    tck_fall && state_reg == SHIFT_DR && sel.byp |=> tdo_reg == $past(bypass_reg);
  endproperty
  a_bypass_tdo: assert property (p_bypass_tdo) else $error("bypass path wrong");

  property p_bsr_capture;
    @(posedge core_clk) disable iff (!nrst)
    cap_dr && sel.bsr |=> bsr_reg == $past(cap_vec) && (bsr_reg & PINLESS_MASK) == (PINLESS_VALUE & PINLESS_MASK);
  endproperty
  a_bsr_capture: assert property (p_bsr_capture) else $error("boundary capture wrong");

  property p_bsr_shift;
    @(posedge core_clk) disable iff (!nrst)
    sh_dr && sel.bsr |=> bsr_reg == {$past(jtag_s.tdi), $past(bsr_reg[BSR_LEN-1:1])};
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("boundary shift wrong");

  property p_id_shift;
    @(posedge core_clk) disable iff (!nrst)
    sh_dr && sel.idr |=> id_shift_reg == {$past(jtag_s.tdi), $past(id_shift_reg[ID_W-1:1])};
  endproperty
  a_id_shift: assert property (p_id_shift) else $error("id shift wrong");

  property p_bypass_capture;
    @(posedge core_clk) disable iff (!nrst)
    cap_dr && sel.byp |=> !bypass_reg;
  endproperty
  a_bypass_capture: assert property (p_bypass_capture) else $error("bypass capture wrong");

  property p_tdo_release;
    @(posedge core_clk) disable iff (!nrst)
    tck_fall && !shifting |=> !tdo_oe_reg;
  endproperty
  a_tdo_release: assert property (p_tdo_release) else $error("tdo enabled outside shift");

  property p_extest_dr_update;
    @(posedge core_clk) disable iff (!nrst)
    tck_fall && upd_dr_extest |=> drive_data == $past(bsr_reg) && drive_en;
  endproperty
  a_extest_dr_update: assert property (p_extest_dr_update) else $error("extest update-dr drive wrong");

  property p_extest_decode;
    @(posedge core_clk) disable iff (!nrst)
    ir_reg == INS_EXTEST |-> drive_en && sel.bsr && !outputs_highz;
  endproperty
  a_extest_decode: assert property (p_extest_decode) else $error("extest decode wrong");

  property p_extest_update;
    @(posedge core_clk) disable iff (!nrst)
    tck_fall && upd_ir_extest |=> drive_data == $past(bsr_reg);
  endproperty
  a_extest_update: assert property (p_extest_update) else $error("extest drive wrong");

  property p_id_capture;
    @(posedge core_clk) disable iff (!nrst)
    cap_dr && sel.idr |=> id_shift_reg == $past(rom_word) && id_shift_reg[0] == ID_PRESENCE;
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id capture wrong");

  property p_tlr_ir;
    @(posedge core_clk) disable iff (!nrst)
    in_tlr |=> ir_reg == INS_IDCODE;
  endproperty
  a_tlr_ir: assert property (p_tlr_ir) else $error("idcode not loaded in reset state");

  property p_highz;
    @(posedge core_clk) disable iff (!nrst)
    ir_reg == INS_SAMPLE_HIGHZ |-> outputs_highz && !drive_en && sel.bsr;
  endproperty
  a_highz: assert property (p_highz) else $error("sample_highz effect wrong");

  property p_reserved;
    @(posedge core_clk) disable iff (!nrst)
    ir_reg == 3'h3 |-> sel.byp && !sel.bsr && !outputs_highz;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not bypass");

  property p_five_ones;
    @(posedge core_clk) disable iff (!nrst)
    ones_cnt_reg == TLR_TMS_EDGES |-> in_tlr;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("five tms-high edges missed reset");

  c_ir_update: cover property (@(posedge core_clk) disable iff (!nrst) tck_fall && state_reg == UPDATE_IR);
  c_id_shift: cover property (@(posedge core_clk) disable iff (!nrst) sh_dr && sel.idr);
  c_extest: cover property (@(posedge core_clk) disable iff (!nrst) tck_fall && upd_ir_extest);
  c_highz: cover property (@(posedge core_clk) disable iff (!nrst) outputs_highz);
endmodule
`default_nettype wire

//--- hw/tap_sync.sv
// two-flop synchroniser for a group of pins
// assumes inputs are asynchronous to core_clk
`default_nettype none
module tap_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

//--- verif/jtag_ctl.sv
// model of the external boundary-scan controller driving the test pins
// assumes core_clk only paces its steps; tck has a 400 ns period and stands still between frames
`default_nettype none
module jtag_ctl
  import tap_pkg::*;
(
  input wire logic core_clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output var jtag_pins_s pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // tck low, tms and tdi at their pull-up level
  initial pins = 3'b011;

  // one tck period; tdo is taken late in the high phase, before the fall moves it
  task automatic tick(input logic ms, input logic di, output logic so);
    pins.tms = ms;
    pins.tdi = di;
    repeat (4) @(posedge core_clk);
    #1 pins.tck = 1'b1;
    repeat (4) @(posedge core_clk);
    // a released tdo shows the inverse so a late enable is caught
    so = tdo_oe ? tdo : ~tdo;
    #1 pins.tck = 1'b0;
  endtask

  // from run-test/idle into a shift state, n bits lsb first, stops in exit1
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b1, b);
    if (ir) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask

  // exit1 to update, then back to run-test/idle
  task automatic finish();
    logic b;
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask

  // five tms-high rises, then run-test/idle
  task automatic to_reset();
    logic b;
    repeat (5) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the test port instruction logic
// assumes the controller model in jtag_ctl and the package constants
`default_nettype none
`define CHK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module tb_top
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] pl_mask = 16'h8001;
  localparam logic [15:0] pl_val = 16'hffff;
  localparam logic [10:0] maker = 11'h2a5; // arbitrary value

  logic core_clk;
  logic nrst;
  jtag_pins_s pins;
  logic tdo;
  logic tdo_oe;
  logic [15:0] pin_in;
  logic [15:0] drive_data;
  logic drive_en;
  logic outputs_highz;
  int miscompares = 0;
  int total_checks = 0;
  logic [2:0] cur = INS_IDCODE;
  logic [15:0] bsr = '0;
  logic [2:0] codes [9] = '{INS_SAMPLE_PRELOAD, INS_EXTEST, INS_SAMPLE_HIGHZ, INS_IDCODE, 3'h3,
    INS_BYPASS, 3'h5, 3'h6, INS_EXTEST};

  tap_instruction_logic #(.BSR_LEN(16), .PINLESS_MASK(pl_mask), .PINLESS_VALUE(pl_val), .MAKER_CODE(maker)) DUT (
    .core_clk(core_clk), .nrst(nrst), .jtag_in(pins), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
    .drive_data(drive_data), .drive_en(drive_en), .outputs_highz(outputs_highz));

  jtag_ctl ctl (.core_clk(core_clk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // expected 32 bits out of a data scan
  function automatic logic [31:0] exp_dr(input logic [2:0] c, input logic [15:0] p, input logic [31:0] d);
    if (c == INS_EXTEST || c == INS_SAMPLE_HIGHZ || c == INS_SAMPLE_PRELOAD)
      return {d[15:0], (p & ~pl_mask) | (pl_val & pl_mask)};
    if (c == INS_IDCODE)
      return {20'h0_0000, maker, 1'b1};
    return {d[30:0], 1'b0};
  endfunction

  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic load_ir(input logic [2:0] c);
    logic [31:0] q;
    ctl.scan(1'b1, 3, {29'h0, c}, q);
    `CHK("ir_capture", 3'h1, q[2:0])
    `CHK("drive_en_hold", cur == INS_EXTEST, drive_en)
    `CHK("highz_hold", cur == INS_SAMPLE_HIGHZ, outputs_highz)
    ctl.finish();
    cur = c;
    `CHK("drive_en", c == INS_EXTEST, drive_en)
    `CHK("highz", c == INS_SAMPLE_HIGHZ, outputs_highz)
    if (c == INS_EXTEST) `CHK("drive_update_ir", bsr, drive_data)
  endtask

  task automatic dr_read(input logic [2:0] c);
    logic [31:0] d;
    logic [31:0] q;
    logic [31:0] e;
    logic [31:0] m;
    // pins stay put from here through the capture
    pin_in = 16'($urandom);
    d = $urandom;
    e = exp_dr(c, pin_in, d);
    m = (c == INS_IDCODE) ? 32'h0000_0fff : 32'hffff_ffff;
    ctl.scan(1'b0, 32, d, q);
    `CHK("dr_out", e & m, q & m)
    ctl.finish();
    if (c == INS_EXTEST || c == INS_SAMPLE_HIGHZ || c == INS_SAMPLE_PRELOAD)
      bsr = d[31:16];
    if (c == INS_EXTEST) `CHK("drive_update_dr", bsr, drive_data)
  endtask

  initial begin
    nrst = 1'b0;
    pin_in = '0;
    void'($urandom(32'h1350_bfa8));
    repeat (8) @(posedge core_clk);
    #1 nrst = 1'b1;
    `CHK("highz_reset", 1'b0, outputs_highz)
    ctl.to_reset();
    dr_read(INS_IDCODE);
    foreach (codes[i]) begin
      load_ir(codes[i]);
      dr_read(codes[i]);
    end
    nrst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 nrst = 1'b1;
    cur = INS_IDCODE;
    bsr = '0;
    `CHK("drive_en_nrst", 1'b0, drive_en)
    `CHK("drive_data_nrst", 16'h0000, drive_data)
    ctl.to_reset();
    dr_read(INS_IDCODE);
    load_ir(INS_EXTEST);
    ctl.to_reset();
    cur = INS_IDCODE;
    `CHK("drive_en_tlr", 1'b0, drive_en)
    dr_read(INS_IDCODE);
    complete_run();
  end

  initial begin
    #2_000_000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
